// >>> hdl/async_serial_char_framer.v
// Serial character framer: baud generator, transmitter, receiver, autobaud.
`timescale 1ns/1ps
`include "async_serial_char_framer_map.vh"
module async_serial_char_framer (
  // Clock, reset, enable
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  // Configuration
  input  wire        serial_port_enable_bit_i,
  input  wire        transmitter_enable_bit_i,
  input  wire        receiver_enable_i,
  input  wire        sync_mode_i,
  input  wire        sync_master_i,
  input  wire        nine_bit_i,
  input  wire        address_detect_i,
  input  wire        brg16_i,
  input  wire [15:0] divisor_i,
  input  wire        divisor_load_i,
  input  wire        auto_baud_start_i,
  input  wire        wake_enable_i,
  // Transmit side
  input  wire [7:0]  tx_data_i,
  input  wire        ninth_transmit_bit_i,
  input  wire        send_break_i,
  input  wire        tx_write_i,
  output reg         tx_buffer_empty_o,
  output reg         tx_shift_empty_o,
  // Receive side
  input  wire        rx_read_i,
  input  wire        overrun_clear_i,
  output reg  [7:0]  rx_data_o,
  output reg         rx_ninth_o,
  output reg         rx_frame_err_o,
  output reg         rx_avail_o,
  output reg         overrun_o,
  // Status
  output reg  [15:0] brg_divisor_o,
  output reg         auto_baud_done_o,
  output reg         wake_o,
  // Pins
  input  wire        receive_or_sync_data_pin_i,
  output reg         receive_or_sync_data_pin_o,
  output reg         receive_or_sync_data_pin_oe_o,
  input  wire        transmit_or_clock_pin_i,
  output reg         transmit_or_clock_pin_o,
  output reg         transmit_or_clock_pin_oe_o,
  output reg         clc_tx_o
);
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;
  localparam RX_IDLE  = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA  = 4'b0100;
  localparam RX_STOP  = 4'b1000;

  reg  [2:0]  dt_sync_reg;
  reg  [2:0]  ck_sync_reg;
  reg         dt_filt_reg;
  reg         ck_filt_reg;
  reg         dt_prev_reg;
  reg  [15:0] brg_cnt_reg;
  reg         tick_reg;
  reg  [3:0]  sck_cnt_reg;
  reg         sclk_prev_reg;
  reg  [1:0]  tx_state_reg;
  reg  [13:0] tx_sh_reg;
  reg  [3:0]  tx_bits_reg;
  reg  [3:0]  tx_last_reg;
  reg  [3:0]  tx_tick_reg;
  reg         hold_full_reg;
  reg  [8:0]  hold_word_reg;
  reg         hold_brk_reg;
  reg  [3:0]  rx_state_reg;
  reg  [3:0]  rx_tick_reg;
  reg  [3:0]  rx_bits_reg;
  reg  [8:0]  rx_sh_reg;
  reg         push_reg;
  reg  [9:0]  push_word_reg;
  reg  [9:0]  fifo_mem [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  fifo_cnt_reg;
  reg         ab_busy_reg;
  reg         ab_run_reg;
  reg  [2:0]  ab_edges_reg;
  reg  [22:0] ab_cnt_reg;

  wire        dt_fall   = dt_prev_reg & ~dt_filt_reg;
  wire        dt_rise   = ~dt_prev_reg & dt_filt_reg;
  wire        tx_busy   = tx_state_reg[1];
  wire        sck_run   = serial_port_enable_bit_i & sync_mode_i & sync_master_i & (tx_busy | receiver_enable_i);
  wire        sclk_now  = sync_master_i ? sck_cnt_reg[3] : ck_filt_reg;
  wire        sclk_fall = sclk_prev_reg & ~sclk_now;
  wire        sclk_rise = ~sclk_prev_reg & sclk_now;
  wire [15:0] brg_limit = brg16_i ? brg_divisor_o : {8'h00, brg_divisor_o[7:0]};
  wire        tx_adv    = sync_mode_i ? sclk_fall : (tick_reg & (tx_tick_reg == `OVS_LAST));
  wire        tx_line   = tx_busy ? tx_sh_reg[0] : 1'b1;
  wire [3:0]  rx_nbits  = nine_bit_i ? `SYNC_BITS9 : `SYNC_BITS8;
  wire        fifo_pop  = rx_read_i & (fifo_cnt_reg != 2'h0);
  wire        fifo_put  = push_reg & (fifo_cnt_reg != `FIFO_DEPTH);

  // Final word of a character: eight-bit data sits in the top of the shifter
  function [8:0] rx_align;
    input [8:0] sh;
    input       nine;
    begin
      rx_align = nine ? sh : {1'b0, sh[8:1]};
    end
  endfunction

  // Pin synchronisers; a level counts once stages two and three agree
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dt_sync_reg <= 3'h7;
      ck_sync_reg <= 3'h7;
      dt_filt_reg <= 1'b1;
      ck_filt_reg <= 1'b1;
      dt_prev_reg <= 1'b1;
    end else if (clk_en_i) begin
      dt_sync_reg <= {dt_sync_reg[1:0], receive_or_sync_data_pin_i};
      ck_sync_reg <= {ck_sync_reg[1:0], transmit_or_clock_pin_i};
      if (dt_sync_reg[1] == dt_sync_reg[2])
        dt_filt_reg <= dt_sync_reg[2];
      if (ck_sync_reg[1] == ck_sync_reg[2])
        ck_filt_reg <= ck_sync_reg[2];
      dt_prev_reg <= dt_filt_reg;
    end
  end

  // [R9] [R23] Divider yields sixteen ticks per bit
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brg_cnt_reg   <= 16'h0000;
      tick_reg      <= 1'b0;
      sck_cnt_reg   <= 4'h0;
      sclk_prev_reg <= 1'b1;
    end else if (clk_en_i) begin
      if (!serial_port_enable_bit_i || brg_cnt_reg >= brg_limit)
        brg_cnt_reg <= 16'h0000;
      else
        brg_cnt_reg <= brg_cnt_reg + 16'h0001;
      tick_reg <= serial_port_enable_bit_i & (brg_cnt_reg >= brg_limit);
      // [R17] Master clock: low half then high half per bit
      if (!sck_run)
        sck_cnt_reg <= 4'h0;
      else if (tick_reg)
        sck_cnt_reg <= sck_cnt_reg + 4'h1;
      sclk_prev_reg <= sclk_now;
    end
  end

  // [R15] Autobaud: five falling edges of a 55h span eight bits
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ab_busy_reg      <= 1'b0;
      ab_run_reg       <= 1'b0;
      ab_edges_reg     <= 3'h0;
      ab_cnt_reg       <= 23'h000000;
      auto_baud_done_o <= 1'b0;
      brg_divisor_o    <= `DIV_RESET;
      wake_o           <= 1'b0;
    end else if (clk_en_i) begin
      if (auto_baud_start_i) begin
        ab_busy_reg      <= 1'b1;
        ab_run_reg       <= 1'b0;
        ab_edges_reg     <= 3'h0;
        ab_cnt_reg       <= 23'h000000;
        auto_baud_done_o <= 1'b0;
      end else if (ab_busy_reg) begin
        // Every cycle counts, edge cycles too, so eight bits give an exact span
        if (ab_run_reg)
          ab_cnt_reg <= ab_cnt_reg + 23'h000001;
        if (dt_fall) begin
          ab_edges_reg <= ab_edges_reg + 3'h1;
          ab_run_reg   <= 1'b1;
          if (!ab_run_reg)
            ab_cnt_reg <= 23'h000001;
          if (ab_edges_reg == `AB_LAST_EDGE) begin
            ab_busy_reg      <= 1'b0;
            auto_baud_done_o <= 1'b1;
            brg_divisor_o    <= ab_cnt_reg[22:`AB_SHIFT] - 16'h0001;
          end
        end
      end else if (divisor_load_i) begin
        brg_divisor_o <= divisor_i;
      end
      // [R16] Wake raised on line falling, dropped when it returns high
      if (!wake_enable_i || dt_rise)
        wake_o <= 1'b0;
      else if (dt_fall)
        wake_o <= 1'b1;
    end
  end

  // Transmit holding buffer and shifter
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_reg  <= TX_IDLE;
      tx_sh_reg     <= 14'h3FFF;
      tx_bits_reg   <= 4'h0;
      tx_last_reg   <= 4'h0;
      tx_tick_reg   <= 4'h0;
      hold_full_reg <= 1'b0;
      hold_word_reg <= 9'h000;
      hold_brk_reg  <= 1'b0;
    end else if (clk_en_i) begin
      if (!transmitter_enable_bit_i || !serial_port_enable_bit_i) begin
        tx_state_reg  <= TX_IDLE;
        hold_full_reg <= 1'b0;
      end else begin
        // [R25] Ninth bit captured above the eight data bits
        if (tx_write_i && !hold_full_reg) begin
          hold_full_reg <= 1'b1;
          hold_word_reg <= {ninth_transmit_bit_i, tx_data_i};
          hold_brk_reg  <= send_break_i;
        end
        if (tick_reg)
          tx_tick_reg <= tx_tick_reg + 4'h1;
        case (tx_state_reg)
          TX_IDLE: begin
            // [R21] Buffer moves only once the stop bit has finished
            // [R4] Async load waits for a tick so the start bit is whole
            if (hold_full_reg && (sync_mode_i || tick_reg)) begin
              hold_full_reg <= 1'b0;
              tx_state_reg  <= TX_SEND;
              tx_bits_reg   <= 4'h0;
              tx_tick_reg   <= 4'h0;
              if (sync_mode_i) begin
                tx_sh_reg   <= {5'h1F, hold_word_reg};
                tx_last_reg <= rx_nbits;
              // [R14] Thirteen space bits then one mark
              end else if (hold_brk_reg) begin
                tx_sh_reg   <= {1'b1, 13'h0000};
                tx_last_reg <= `BREAK_BITS;
              // [R2] [R3] [R6] [R8] [R10] Start, data LSB first, stop; no parity
              end else if (nine_bit_i) begin
                tx_sh_reg   <= {4'hF, hold_word_reg, 1'b0};
                tx_last_reg <= `FRAME_BITS9;
              end else begin
                tx_sh_reg   <= {5'h1F, hold_word_reg[7:0], 1'b0};
                tx_last_reg <= `FRAME_BITS8;
              end
            end
          end
          TX_SEND: begin
            // [R4] [R5] Line held for a whole bit, no return between bits
            if (tx_adv) begin
              tx_sh_reg   <= {1'b1, tx_sh_reg[13:1]};
              tx_bits_reg <= tx_bits_reg + 4'h1;
              if (tx_bits_reg == tx_last_reg - 4'h1)
                tx_state_reg <= TX_IDLE;
            end
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Pin drivers; all registered
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_or_clock_pin_o       <= 1'b1;
      transmit_or_clock_pin_oe_o    <= 1'b0;
      receive_or_sync_data_pin_o    <= 1'b1;
      receive_or_sync_data_pin_oe_o <= 1'b0;
      clc_tx_o                      <= 1'b1;
      tx_buffer_empty_o             <= 1'b1;
      tx_shift_empty_o              <= 1'b1;
    end else if (clk_en_i) begin
      // [R1] [R19] Idle mark, same line to logic cell and, in async mode, to pin; sync mode puts the clock on the pin
      transmit_or_clock_pin_o    <= sync_mode_i ? sck_cnt_reg[3] : tx_line;
      transmit_or_clock_pin_oe_o <= serial_port_enable_bit_i & (~sync_mode_i | sync_master_i);
      clc_tx_o                   <= tx_line;
      // [R18] Data pin driven only while a sync character goes out
      receive_or_sync_data_pin_o    <= tx_line;
      receive_or_sync_data_pin_oe_o <= serial_port_enable_bit_i & sync_mode_i & tx_busy;
      tx_buffer_empty_o             <= ~hold_full_reg;
      tx_shift_empty_o              <= ~tx_busy;
    end
  end

  // [R7] Receiver independent of transmitter in async mode, shares format and ticks
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg  <= RX_IDLE;
      rx_tick_reg   <= 4'h0;
      rx_bits_reg   <= 4'h0;
      rx_sh_reg     <= 9'h000;
      push_reg      <= 1'b0;
      push_word_reg <= 10'h000;
    end else if (clk_en_i) begin
      push_reg <= 1'b0;
      if (!receiver_enable_i || !serial_port_enable_bit_i || ab_busy_reg) begin
        rx_state_reg <= RX_IDLE;
        rx_bits_reg  <= 4'h0;
      end else if (sync_mode_i) begin
        // Sample on rising clock only while the pin is not ours
        rx_state_reg <= RX_IDLE;
        if (sclk_rise && !tx_busy) begin
          rx_sh_reg   <= {dt_filt_reg, rx_sh_reg[8:1]};
          rx_bits_reg <= rx_bits_reg + 4'h1;
          if (rx_bits_reg == rx_nbits - 4'h1) begin
            rx_bits_reg   <= 4'h0;
            push_reg      <= 1'b1;
            push_word_reg <= {1'b0, rx_align({dt_filt_reg, rx_sh_reg[8:1]}, nine_bit_i)};
          end
        end
      end else begin
        if (tick_reg)
          rx_tick_reg <= rx_tick_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE: begin
            if (!dt_filt_reg) begin
              rx_state_reg <= RX_START;
              rx_tick_reg  <= 4'h0;
            end
          end
          RX_START: begin
            // Mid-start recheck rejects glitches
            if (tick_reg && rx_tick_reg == `OVS_MID) begin
              rx_tick_reg  <= 4'h0;
              rx_bits_reg  <= 4'h0;
              rx_state_reg <= dt_filt_reg ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (tick_reg && rx_tick_reg == `OVS_LAST) begin
              rx_sh_reg   <= {dt_filt_reg, rx_sh_reg[8:1]};
              rx_bits_reg <= rx_bits_reg + 4'h1;
              if (rx_bits_reg == rx_nbits - 4'h1)
                rx_state_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (tick_reg && rx_tick_reg == `OVS_LAST) begin
              rx_state_reg  <= RX_IDLE;
              // [R13] Address mode drops characters whose ninth bit is clear
              push_reg      <= ~(address_detect_i & nine_bit_i & ~rx_sh_reg[8]);
              // [R12] [R20] Space at stop position flags framing error
              push_word_reg <= {~dt_filt_reg, rx_align(rx_sh_reg, nine_bit_i)};
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // [R24] Two-entry receive FIFO; overrun loses the new character
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg     <= 1'b0;
      rd_ptr_reg     <= 1'b0;
      fifo_cnt_reg   <= 2'h0;
      fifo_mem[0]    <= 10'h000;
      fifo_mem[1]    <= 10'h000;
      overrun_o      <= 1'b0;
      rx_data_o      <= 8'h00;
      rx_ninth_o     <= 1'b0;
      rx_frame_err_o <= 1'b0;
      rx_avail_o     <= 1'b0;
    end else if (clk_en_i) begin
      if (fifo_put) begin
        fifo_mem[wr_ptr_reg] <= push_word_reg;
        wr_ptr_reg           <= ~wr_ptr_reg;
      end
      if (fifo_pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (fifo_put && !fifo_pop)
        fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      else if (fifo_pop && !fifo_put)
        fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
      // [R11] Set wins over clear
      if (push_reg && fifo_cnt_reg == `FIFO_DEPTH)
        overrun_o <= 1'b1;
      else if (overrun_clear_i)
        overrun_o <= 1'b0;
      {rx_frame_err_o, rx_ninth_o, rx_data_o} <= fifo_mem[rd_ptr_reg];
      rx_avail_o <= fifo_cnt_reg != 2'h0;
    end
  end
endmodule

// >>> inc/async_serial_char_framer_map.vh
// Constants for the serial character framer.
// Function
// [R1] Idle transmit line rests at mark (one).
// [R2] Frame is one start bit, eight or nine data bits, stop bits.
// [R3] Start bit is space, every stop bit is mark.
// [R4] Every bit lasts exactly one bit period of the baud setting.
// [R5] Equal successive bits hold the line level with no neutral return.
// [R6] Data bits go out and come in least significant bit first.
// [R7] Transmitter and receiver run independently with shared format and baud.
// [R8] No hardware parity; software may carry parity in ninth bit.
// [R9] Baud generator divides system clock with 8-bit or 16-bit divisor.
// [R10] Character length selectable between eight and nine data bits.
// [R11] Receive buffer overrun is detected and reported.
// [R12] Framing error of a received character is detected and reported.
// [R13] Nine-bit mode offers address detection using the ninth bit.
// [R14] Transmitter can send a break of 13 bit periods.
// [R15] Incoming baud rate is measured and the generator calibrated to it.
// [R16] A received break can wake the device from low power.
// [R17] Full-duplex asynchronous or half-duplex synchronous, master or slave.
// [R18] Synchronous mode shares receive and data pin; direction switches automatically.
// [R19] Transmit output goes to transmit/clock pin and to logic cell.
// [R20] Stop position sampled at space raises a framing error.
// [R21] One stop bit per character; next start only after stop completes.
// [R22] Software enables transmitter and port, clears sync, before async sending.
// [R23] Receive line sampled at sixteen times the baud rate.
// [R24] Each received character moves at once into a two-entry FIFO.
// [R25] In nine-bit mode the ninth bit is the most significant data bit.
`ifndef ASYNC_SERIAL_CHAR_FRAMER_MAP_VH
`define ASYNC_SERIAL_CHAR_FRAMER_MAP_VH
`define DIV_RESET      16'h0000
`define OVS_LAST       4'hF
`define OVS_MID        4'h7
`define FRAME_BITS8    4'hA
`define FRAME_BITS9    4'hB
`define BREAK_BITS     4'hE
`define SYNC_BITS8     4'h8
`define SYNC_BITS9     4'h9
`define AB_LAST_EDGE   3'h4
`define AB_SHIFT       7
`define FIFO_DEPTH     2'h2
`endif

// >>> verification/async_serial_char_framer_asserts.sv
// Concurrent checks on the serial framer's pins and status outputs.
`timescale 1ns/1ps
module framer_checker (
  // Clock and control
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        clk_en_i,
  input wire        serial_port_enable_bit_i,
  input wire        sync_mode_i,
  input wire        sync_master_i,
  input wire        brg16_i,
  input wire        wake_enable_i,
  input wire        auto_baud_start_i,
  input wire        overrun_clear_i,
  // Observed outputs
  input wire        tx_buffer_empty_o,
  input wire        tx_shift_empty_o,
  input wire        rx_avail_o,
  input wire        overrun_o,
  input wire [15:0] brg_divisor_o,
  input wire        auto_baud_done_o,
  input wire        wake_o,
  input wire        receive_or_sync_data_pin_oe_o,
  input wire        transmit_or_clock_pin_o,
  input wire        transmit_or_clock_pin_oe_o,
  input wire        clc_tx_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire [20:0] bit_len = ({5'h00, brg16_i ? brg_divisor_o : {8'h00, brg_divisor_o[7:0]}} + 21'h1) << 4;
  reg  [24:0] run_reg;
  reg         last_reg;
  // Starts huge so the first start bit after reset needs no history
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg  <= 25'h1000000;
      last_reg <= 1'b1;
    end else if (clk_en_i) begin
      last_reg <= transmit_or_clock_pin_o;
      run_reg  <= (transmit_or_clock_pin_o != last_reg) ? 25'h1 : run_reg + 25'h1;
    end
  end
  sequence s_quiet;
    (tx_buffer_empty_o && tx_shift_empty_o && !sync_mode_i) [*4];
  endsequence
  sequence s_rise;
    !sync_mode_i && transmit_or_clock_pin_o && !last_reg;
  endsequence
  sequence s_fall;
    !sync_mode_i && !transmit_or_clock_pin_o && last_reg;
  endsequence
  property p_idle_mark;
    s_quiet |-> transmit_or_clock_pin_o;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("tx line not at mark while idle");
  property p_low_len;
    s_rise |-> (run_reg % bit_len) == 25'h0;
  endproperty
  a_low_len: assert property (p_low_len) else $error("low run not whole bit periods");
  property p_stop_len;
    s_fall |-> run_reg >= bit_len;
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("mark before start shorter than a bit");
  property p_break_max;
    (!sync_mode_i && !transmit_or_clock_pin_o && !last_reg) |-> run_reg < bit_len * 13;
  endproperty
  a_break_max: assert property (p_break_max) else $error("low run longer than a break");
  property p_pin_oe;
    clk_en_i |=> transmit_or_clock_pin_oe_o == $past(serial_port_enable_bit_i && (!sync_mode_i || sync_master_i));
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("tx pin enable wrong");
  property p_clc;
    !sync_mode_i |-> clc_tx_o == transmit_or_clock_pin_o;
  endproperty
  a_clc: assert property (p_clc) else $error("logic cell copy differs from tx pin");
  property p_data_oe;
    (!sync_mode_i) [*2] |-> !receive_or_sync_data_pin_oe_o;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data pin driven in async mode");
  property p_ovr_hold;
    overrun_o && !overrun_clear_i |=> overrun_o;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped without clear");
  property p_ovr_full;
    $rose(overrun_o) |-> rx_avail_o;
  endproperty
  a_ovr_full: assert property (p_ovr_full) else $error("overrun with empty fifo");
  property p_wake;
    $rose(wake_o) |-> $past(wake_enable_i);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without enable");
  property p_abd;
    auto_baud_start_i |=> !auto_baud_done_o;
  endproperty
  a_abd: assert property (p_abd) else $error("baud done not cleared by start");
endmodule
bind async_serial_char_framer framer_checker framer_checker_inst (.*);

// >>> verification/remote_serial_peer.sv
// Remote asynchronous transceiver model on the framer's line pins.
`timescale 1ns/1ps
module remote_serial_peer (
  // Clock and line
  input  wire clock_i,
  input  wire line_i,
  input  wire nine_i,
  output reg  line_o
);
  reg [8:0] got;
  integer   cnt;
  integer   bitc;
  integer   k;
  initial begin
    line_o = 1'b1;
    cnt    = 0;
    bitc   = 32;
  end
  // start, LSB first, stop, rest at mark
  task send(input [8:0] d, input nine, input stp);
    reg [10:0] f;
    integer    j;
    begin
      f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
      for (j = 0; j < (nine ? 11 : 10); j = j + 1) begin
        line_o = f[j];
        repeat (bitc) @(negedge clock_i);
      end
      line_o = 1'b1;
    end
  endtask
  // sample at bit centres, stop not judged here
  always begin
    @(negedge line_i);
    repeat (bitc / 2) @(negedge clock_i);
    got = 9'h000;
    for (k = 0; k < (nine_i ? 9 : 8); k = k + 1) begin
      repeat (bitc) @(negedge clock_i);
      got[k] = line_i;
    end
    repeat (bitc) @(negedge clock_i);
    cnt = cnt + 1;
  end
endmodule

// >>> verification/tb_async_serial_char_framer.sv
// Self-checking bench for the serial character framer.
`timescale 1ns/1ps
module tb_async_serial_char_framer;
  localparam BITC = 32;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, serial_port_enable_bit = 1'b0, transmitter_enable_bit = 1'b0, sync_mode_i = 1'b0, sync_master_i = 1'b0;
  logic        nine_bit_i = 1'b0, address_detect_i = 1'b0, divisor_load_i = 1'b0, auto_baud_start_i = 1'b0;
  logic        wake_enable_i = 1'b0, ninth_i = 1'b0, send_break_i = 1'b0, tx_write_i = 1'b0;
  logic        rx_read_i = 1'b0, overrun_clear_i = 1'b0;
  logic [7:0]  tx_data_i = 8'h00, rx_data_o;
  logic        tx_buffer_empty_o, tx_shift_empty_o, rx_ninth_o, rx_frame_err_o, rx_avail_o, overrun_o;
  logic [15:0] brg_divisor_o;
  logic        auto_baud_done_o, wake_o, rx_line, data_o, data_oe, tx_line, tx_oe, clc_tx_o;
  logic [10:0] rows [0:4] = '{{9'h000, 2'b01}, {9'h0FF, 2'b01}, {9'h0A5, 2'b00}, {9'h15A, 2'b11}, {9'h0C3, 2'b10}};
  logic [8:0]  e9;
  int          err_total = 0, checked = 0, i, n;
  async_serial_char_framer async_serial_char_framer_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .serial_port_enable_bit_i(serial_port_enable_bit),
    .transmitter_enable_bit_i(transmitter_enable_bit), .receiver_enable_i(1'b1), .sync_mode_i(sync_mode_i),
    .sync_master_i(sync_master_i), .nine_bit_i(nine_bit_i), .address_detect_i(address_detect_i),
    .brg16_i(1'b0), .divisor_i(16'h0101), .divisor_load_i(divisor_load_i), .auto_baud_start_i(auto_baud_start_i),
    .wake_enable_i(wake_enable_i), .tx_data_i(tx_data_i), .ninth_transmit_bit_i(ninth_i),
    .send_break_i(send_break_i), .tx_write_i(tx_write_i), .tx_buffer_empty_o(tx_buffer_empty_o),
    .tx_shift_empty_o(tx_shift_empty_o), .rx_read_i(rx_read_i), .overrun_clear_i(overrun_clear_i),
    .rx_data_o(rx_data_o), .rx_ninth_o(rx_ninth_o), .rx_frame_err_o(rx_frame_err_o), .rx_avail_o(rx_avail_o),
    .overrun_o(overrun_o), .brg_divisor_o(brg_divisor_o), .auto_baud_done_o(auto_baud_done_o), .wake_o(wake_o),
    .receive_or_sync_data_pin_i(rx_line), .receive_or_sync_data_pin_o(data_o),
    .receive_or_sync_data_pin_oe_o(data_oe), .transmit_or_clock_pin_i(1'b1), .transmit_or_clock_pin_o(tx_line),
    .transmit_or_clock_pin_oe_o(tx_oe), .clc_tx_o(clc_tx_o));
  remote_serial_peer remote_serial_peer_inst (.clock_i(clock_i), .line_i(tx_line), .nine_i(nine_bit_i),
    .line_o(rx_line));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  task step(input int c);
    repeat (c) @(negedge clock_i);
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = tx_shift_empty_o & tx_buffer_empty_o;
      1: pick = rx_avail_o;
      2: pick = tx_buffer_empty_o;
      3: pick = !tx_line;
      default: pick = auto_baud_done_o;
    endcase
  endfunction
  // Bounded so a stuck status ends the run instead of hanging it
  task wait_hi(input int s);
    int c;
    c = 0;
    while (pick(s) !== 1'b1 && c < 2000) begin
      step(1);
      c++;
    end
    if (c >= 2000) begin
      err_total++;
      $display("[ERR] %0t wait bound spent on %0d", $time, s);
      stop_test();
    end
  endtask
  task tx(input [8:0] d, input brk);
    {ninth_i, tx_data_i} = d;
    send_break_i = brk;
    tx_write_i = 1'b1;
    step(1);
    tx_write_i = 1'b0;
  endtask
  task pop;
    rx_read_i = 1'b1;
    step(1);
    rx_read_i = 1'b0;
    step(2);
  endtask
  initial begin
    step(6);
    chk({tx_buffer_empty_o, tx_shift_empty_o, rx_avail_o, overrun_o, clc_tx_o, tx_oe}, 16'h0032);
    chk({brg_divisor_o}, 16'h0000);
    rst_n_i = 1'b1;
    serial_port_enable_bit = 1'b1;
    transmitter_enable_bit = 1'b1;
    divisor_load_i = 1'b1;
    step(1);
    divisor_load_i = 1'b0;
    step(2);
    chk({tx_oe, tx_line}, 16'h0003);
    $display("reset test done");
    for (i = 0; i < 5; i++) begin
      nine_bit_i = rows[i][1];
      e9 = rows[i][1] ? rows[i][10:2] : {1'b0, rows[i][9:2]};
      fork
        remote_serial_peer_inst.send(rows[i][10:2], rows[i][1], rows[i][0]);
        tx(rows[i][10:2], 1'b0);
      join
      wait_hi(0);
      wait_hi(1);
      chk(remote_serial_peer_inst.got, e9);
      chk({rows[i][1] & rx_ninth_o, rx_data_o}, e9);
      chk(rx_frame_err_o, !rows[i][0]);
      pop;
      if (!rows[i][0]) begin
        // Re-armed receiver may take the low stop bit as a new start
        step(11 * BITC);
        if (rx_avail_o === 1'b1) pop;
      end
      chk(rx_avail_o, 1'b0);
      $display("row %0d done", i);
    end
    nine_bit_i = 1'b0;
    step(BITC);
    n = remote_serial_peer_inst.cnt;
    tx(9'h031, 1'b0);
    step(4);
    wait_hi(2);
    tx(9'h0C4, 1'b0);
    step(4);
    wait_hi(0);
    step(BITC);
    chk(remote_serial_peer_inst.cnt - n, 2);
    chk(remote_serial_peer_inst.got, 9'h0C4);
    $display("back to back done");
    tx(9'h000, 1'b1);
    wait_hi(3);
    n = 0;
    while (tx_line === 1'b0 && n < 1000) begin
      step(1);
      n++;
    end
    chk(n, 13 * BITC);
    wait_hi(0);
    $display("break done");
    wake_enable_i = 1'b1;
    fork
      remote_serial_peer_inst.send(9'h011, 1'b0, 1'b1);
      begin
        step(12);
        chk(wake_o, 1'b1);
      end
    join
    wake_enable_i = 1'b0;
    remote_serial_peer_inst.send(9'h022, 1'b0, 1'b1);
    remote_serial_peer_inst.send(9'h033, 1'b0, 1'b1);
    step(8);
    chk({overrun_o, rx_data_o}, 16'h0111);
    pop;
    chk(rx_data_o, 8'h22);
    pop;
    chk(rx_avail_o, 1'b0);
    overrun_clear_i = 1'b1;
    step(1);
    overrun_clear_i = 1'b0;
    step(1);
    chk(overrun_o, 1'b0);
    $display("overrun done");
    nine_bit_i = 1'b1;
    address_detect_i = 1'b1;
    remote_serial_peer_inst.send(9'h055, 1'b1, 1'b1);
    step(8);
    chk(rx_avail_o, 1'b0);
    remote_serial_peer_inst.send(9'h1A3, 1'b1, 1'b1);
    wait_hi(1);
    chk({rx_ninth_o, rx_data_o}, 9'h1A3);
    pop;
    address_detect_i = 1'b0;
    nine_bit_i = 1'b0;
    $display("address done");
    remote_serial_peer_inst.bitc = 2 * BITC;
    auto_baud_start_i = 1'b1;
    step(1);
    auto_baud_start_i = 1'b0;
    remote_serial_peer_inst.send(9'h055, 1'b0, 1'b1);
    wait_hi(4);
    chk(brg_divisor_o, 16'(2 * BITC * 8 / 128 - 1));
    $display("autobaud done");
    sync_mode_i = 1'b1;
    sync_master_i = 1'b1;
    step(2);
    chk(tx_oe, 1'b1);
    sync_master_i = 1'b0;
    step(2);
    chk({tx_oe, data_oe}, 16'h0000);
    $display("sync pins done");
    stop_test();
  end
endmodule
